// [hw/ivp_arbiter.sv]
// Interrupt priority arbiter and vector fetch address generator
// How it works
// - Any pending higher-level request beats every pending lower-level request.
// - Within one level, the smallest vector number wins.
// - Fetch address is computed from the software-set table base.
// - After reset, fetch vector 0 for chip reset, 1 for watchdog reset.
// - Vectors 2 to 5 always run at level 3.
// - Debug vectors 6 to 10 accept programmed levels 1 to 3.
// - Low-voltage vector 15 and PLL vector 16 accept levels 1 to 3.
// - Peripheral vectors 17 and up accept levels 0 to 2 only.
// - Each entry is two words: address is base plus twice vector.
`timescale 1ns/1ps
module ivp_arbiter
  import ivp_pkg::*;
#(
  parameter int NUM_VEC = IVP_NUM_VEC_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [NUM_VEC-1:0] irq_req,
  input wire logic [NUM_VEC-1:0] irq_enable,
  input wire logic [NUM_VEC-1:0][IVP_LVL_W-1:0] irq_level,
  input wire logic [IVP_ADDR_W-1:0] vector_table_base,
  input wire logic wdog_reset_cause,
  output ivp_grant_t grant,
  output logic reset_fetch,
  output logic [IVP_VEC_W-1:0] reset_vector,
  output logic [IVP_ADDR_W-1:0] reset_addr
);

  if (NUM_VEC < IVP_NUM_VEC_MIN || NUM_VEC > IVP_NUM_VEC_MAX) begin : g_bad_num
    $error("NUM_VEC out of supported range");
  end

  logic [NUM_VEC-1:0] elig;
  logic [NUM_VEC-1:0][IVP_LVL_W-1:0] eff_lvl;
  ivp_grant_t grant_next;
  ivp_state_t state_reg;
  logic reset_fetch_next;
  logic [IVP_VEC_W-1:0] reset_vector_next;

  // Per-vector class decides the effective level and whether it may compete
  for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
    logic lvl_ok;
    always_comb begin
      lvl_ok = 1'b0;
      eff_lvl[v] = irq_level[v];
      if (v >= IVP_VEC_FIXED_LO && v <= IVP_VEC_FIXED_HI) begin
        eff_lvl[v] = IVP_LVL_3;
        lvl_ok = 1'b1;
      end else if (v >= IVP_VEC_DBG_LO && v <= IVP_VEC_DBG_HI) begin
        lvl_ok = (irq_level[v] != IVP_LVL_0);
      end else if (v == IVP_VEC_SWI2) begin
        eff_lvl[v] = IVP_LVL_2;
        lvl_ok = 1'b1;
      end else if (v == IVP_VEC_SWI1) begin
        eff_lvl[v] = IVP_LVL_1;
        lvl_ok = 1'b1;
      end else if (v == IVP_VEC_SWI0) begin
        eff_lvl[v] = IVP_LVL_0;
        lvl_ok = 1'b1;
      end else if (v == IVP_VEC_LOW_VOLTAGE || v == IVP_VEC_PLL) begin
        lvl_ok = (irq_level[v] != IVP_LVL_0);
      end else if (v >= IVP_VEC_PERIPH_LO) begin
        lvl_ok = (irq_level[v] != IVP_LVL_3);
      end
      // Reset slots and the reserved slot never compete
      elig[v] = irq_req[v] && irq_enable[v] && lvl_ok;
    end
  end

  // Walk from the top vector down so an equal level lets the smaller vector take over
  always_comb begin
    grant_next = IVP_GRANT_RST;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (elig[i] && (!grant_next.valid || eff_lvl[i] >= grant_next.level)) begin
        grant_next.valid = 1'b1;
        grant_next.vector = IVP_VEC_W'(i);
        grant_next.level = eff_lvl[i];
      end
    end
    // Entry is two words; handler targets beyond 21 bits cannot be reached
    grant_next.addr = vector_table_base
      + (IVP_ADDR_W'(grant_next.vector) << IVP_ENTRY_SHIFT);
  end

  // Re-evaluated every cycle; the core samples whatever is current
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      grant <= IVP_GRANT_RST;
    end else begin
      grant <= grant_next;
    end
  end

  // Reset cause is caught on the first edge after release, never under reset
  always_comb begin
    reset_fetch_next = 1'b0;
    reset_vector_next = reset_vector;
    unique case (state_reg)
      IVP_ST_BOOT: begin
        reset_fetch_next = 1'b1;
        reset_vector_next = wdog_reset_cause ? IVP_VEC_WDOG_RST : IVP_VEC_CHIP_RST;
      end
      IVP_ST_RUN: begin
        reset_fetch_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= IVP_ST_BOOT;
    end else begin
      state_reg <= IVP_ST_RUN;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reset_fetch <= 1'b0;
      reset_vector <= IVP_VEC_CHIP_RST;
      reset_addr <= IVP_ADDR_RST;
    end else begin
      reset_fetch <= reset_fetch_next;
      reset_vector <= reset_vector_next;
      if (state_reg == IVP_ST_BOOT) begin
        // Entries 0 and 1 must hold jumps, which software guarantees
        reset_addr <= vector_table_base
          + (IVP_ADDR_W'(reset_vector_next) << IVP_ENTRY_SHIFT);
      end
    end
  end

  // Checks on the arbitration outcome, per vector
  for (genvar v = 0; v < NUM_VEC; v++) begin : g_chk
    level_order_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      elig[v] |=> grant.valid && grant.level >= $past(eff_lvl[v]))
      else $error("granted level below a pending request");
    same_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      elig[v] ##1 (grant.level == $past(eff_lvl[v])) |-> grant.vector <= IVP_VEC_W'(v))
      else $error("larger vector won at equal level");
    winner_elig_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ##1 (grant.valid && grant.vector == IVP_VEC_W'(v))
        |-> $past(elig[v]) && grant.level == $past(eff_lvl[v]))
      else $error("winner was not eligible or carries the wrong level");
    if (v >= IVP_VEC_FIXED_LO && v <= IVP_VEC_FIXED_HI) begin : g_fix
      fixed_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (irq_req[v] && irq_enable[v]) |=> grant.level == IVP_LVL_3)
        else $error("fixed vector not at level 3");
    end
    if ((v >= IVP_VEC_DBG_LO && v <= IVP_VEC_DBG_HI)) begin : g_dbg
      debug_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (irq_req[v] && irq_enable[v] && irq_level[v] == IVP_LVL_0)
          |=> !(grant.valid && grant.vector == IVP_VEC_W'(v)))
        else $error("debug vector granted at level 0");
      debug_legal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (irq_req[v] && irq_enable[v] && irq_level[v] != IVP_LVL_0)
          |=> grant.valid && grant.level >= $past(irq_level[v]))
        else $error("debug request with legal level outranked by a lower level");
    end
    if (v >= IVP_VEC_SWI2 && v <= IVP_VEC_SWI0) begin : g_swi
      soft_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (irq_req[v] && irq_enable[v]) |=> grant.valid && grant.level >= IVP_LVL_W'(IVP_VEC_SWI0 - v))
        else $error("software request outranked by a lower level");
    end
    if (v == IVP_VEC_LOW_VOLTAGE || v == IVP_VEC_PLL) begin : g_mon
      monitor_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (irq_req[v] && irq_enable[v] && irq_level[v] != IVP_LVL_0) |=> grant.valid)
        else $error("monitor request with legal level not granted");
      monitor_refuse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (irq_req[v] && irq_enable[v] && irq_level[v] == IVP_LVL_0)
          |=> !(grant.valid && grant.vector == IVP_VEC_W'(v)))
        else $error("monitor vector granted at level 0");
    end
    if (v >= IVP_VEC_PERIPH_LO) begin : g_per
      periph_range_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ##1 grant.valid && grant.vector == IVP_VEC_W'(v) |-> grant.level != IVP_LVL_3)
        else $error("peripheral granted at level 3");
      periph_legal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (irq_req[v] && irq_enable[v] && irq_level[v] != IVP_LVL_3)
          |=> grant.valid && grant.level >= $past(irq_level[v]))
        else $error("peripheral request with legal level outranked by a lower level");
    end
  end

  table_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 grant.valid |-> grant.addr == $past(vector_table_base)
      + (IVP_ADDR_W'(grant.vector) << IVP_ENTRY_SHIFT))
    else $error("fetch address not base plus twice vector");

  disabled_out_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ((irq_req & irq_enable) == '0) |=> !grant.valid)
    else $error("grant without any enabled request");

  // Reset slots are reached only through the reset path; the reserved slot is never granted
  reserved_slot_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    grant.valid |-> grant.vector != IVP_VEC_CHIP_RST && grant.vector != IVP_VEC_WDOG_RST
      && grant.vector != IVP_VEC_W'(IVP_VEC_RSVD) && int'(grant.vector) < NUM_VEC)
    else $error("reset or reserved slot granted as an interrupt");

  idle_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 !grant.valid |-> grant.vector == '0 && grant.level == '0 && grant.addr == $past(vector_table_base))
    else $error("idle grant carries stale fields");

  reset_vector_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reset_fetch |-> reset_vector == ($past(wdog_reset_cause) ? IVP_VEC_WDOG_RST : IVP_VEC_CHIP_RST)
      ##1 !reset_fetch [*2])
    else $error("reset fetch vector wrong or repeated");

  // Base sampled on the same edge as the reset cause
  reset_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    reset_fetch |-> reset_addr == $past(vector_table_base) + (IVP_ADDR_W'(reset_vector) << IVP_ENTRY_SHIFT))
    else $error("reset fetch address not base plus twice vector");

  reset_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !reset_fetch |-> $stable(reset_vector) && $stable(reset_addr))
    else $error("reset vector moved outside the reset fetch");

endmodule

// [hw/ivp_pkg.sv]
// Constants and types for interrupt vector priority resolution
package ivp_pkg;

  localparam int IVP_VEC_W = 6;
  localparam int IVP_LVL_W = 2;
  localparam int IVP_ADDR_W = 21;
  localparam int IVP_NUM_VEC_DEF = 53;
  localparam int IVP_NUM_VEC_MIN = 17;
  localparam int IVP_NUM_VEC_MAX = 64;

  // Vector numbers
  localparam logic [IVP_VEC_W-1:0] IVP_VEC_CHIP_RST = 6'h00;
  localparam logic [IVP_VEC_W-1:0] IVP_VEC_WDOG_RST = 6'h01;
  localparam int IVP_VEC_FIXED_LO = 2;
  localparam int IVP_VEC_FIXED_HI = 5;
  localparam int IVP_VEC_DBG_LO = 6;
  localparam int IVP_VEC_DBG_HI = 10;
  localparam int IVP_VEC_SWI2 = 11;
  localparam int IVP_VEC_SWI1 = 12;
  localparam int IVP_VEC_SWI0 = 13;
  localparam int IVP_VEC_RSVD = 14;
  localparam int IVP_VEC_LOW_VOLTAGE = 15;
  localparam int IVP_VEC_PLL = 16;
  localparam int IVP_VEC_PERIPH_LO = 17;

  // Priority levels
  localparam logic [IVP_LVL_W-1:0] IVP_LVL_0 = 2'h0;
  localparam logic [IVP_LVL_W-1:0] IVP_LVL_1 = 2'h1;
  localparam logic [IVP_LVL_W-1:0] IVP_LVL_2 = 2'h2;
  localparam logic [IVP_LVL_W-1:0] IVP_LVL_3 = 2'h3;

  // Two words per table entry
  localparam int IVP_ENTRY_SHIFT = 1;

  // Reset values
  localparam logic [IVP_ADDR_W-1:0] IVP_ADDR_RST = 21'h00000;

  typedef struct packed {
    logic valid;
    logic [IVP_VEC_W-1:0] vector;
    logic [IVP_LVL_W-1:0] level;
    logic [IVP_ADDR_W-1:0] addr;
  } ivp_grant_t;

  localparam ivp_grant_t IVP_GRANT_RST = '{valid: 1'b0, vector: 6'h00, level: 2'h0, addr: 21'h00000};

  typedef enum logic [1:0] {
    IVP_ST_BOOT = 2'b01,
    IVP_ST_RUN = 2'b10
  } ivp_state_t;

endpackage

// [testbench/ivp_core_model.sv]
// Processor core stand-in that fetches the entry a grant points at
`timescale 1ns/1ps
module ivp_core_model
  import ivp_pkg::*;
(
  input wire ivp_grant_t grant,
  input wire logic reset_fetch,
  input wire logic [IVP_ADDR_W-1:0] reset_addr,
  output logic [IVP_ADDR_W-1:0] fetch_addr,
  output logic fetch_is_call
);
  // Reset entries hold jumps, every other entry a call
  always_comb begin
    fetch_addr = reset_fetch ? reset_addr : grant.addr;
    fetch_is_call = !reset_fetch;
  end
endmodule

// [testbench/tb.sv]
// Self-checking bench for the vector priority arbiter
`timescale 1ns/1ps
module tb;
  import ivp_pkg::*;
  localparam int NV = 53;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wdog_reset_cause = 1'b0;
  logic [NV-1:0] irq_req = '0;
  logic [NV-1:0] irq_enable = '0;
  logic [NV-1:0][IVP_LVL_W-1:0] irq_level = '0;
  logic [IVP_ADDR_W-1:0] vector_table_base = '0;
  ivp_grant_t grant;
  ivp_grant_t exp_g;
  logic reset_fetch;
  logic fetch_is_call;
  logic [IVP_VEC_W-1:0] reset_vector;
  logic [IVP_ADDR_W-1:0] reset_addr;
  logic [IVP_ADDR_W-1:0] fetch_addr;
  int failures = 0;
  int checks = 0;
  int seed = 36;
  int cyc = 0;
  ivp_arbiter #(.NUM_VEC(NV)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .irq_req(irq_req),
    .irq_enable(irq_enable), .irq_level(irq_level), .vector_table_base(vector_table_base),
    .wdog_reset_cause(wdog_reset_cause), .grant(grant), .reset_fetch(reset_fetch),
    .reset_vector(reset_vector), .reset_addr(reset_addr));
  ivp_core_model core (.grant(grant), .reset_fetch(reset_fetch), .reset_addr(reset_addr),
    .fetch_addr(fetch_addr), .fetch_is_call(fetch_is_call));
  initial forever #4 clk_sys = ~clk_sys;
  // Ceiling well above the roughly 420 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // Highest level wins, scanning down so a lower vector replaces an equal level
  function automatic ivp_grant_t expect_grant();
    ivp_grant_t g;
    int l;
    g = '0;
    for (int v = NV - 1; v >= 2; v--) begin
      l = (v <= 5) ? 3 : (v == 11) ? 2 : (v == 12) ? 1 : (v == 13) ? 0 : int'(irq_level[v]);
      if (v == 14 || !irq_req[v] || !irq_enable[v] || (v >= 17 && l == 3)) continue;
      if (v >= 6 && v <= 16 && (v < 11 || v > 13) && l == 0) continue;
      if (!g.valid || l >= int'(g.level)) begin
        g.valid = 1'b1;
        g.vector = v[5:0];
        g.level = l[1:0];
        g.addr = vector_table_base + 21'(2 * v);
      end
    end
    return g;
  endfunction
  task automatic do_reset(input logic cause);
    sys_rst = 1'b1;
    wdog_reset_cause = cause;
    vector_table_base = 21'($random(seed));
    repeat (4) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    check(grant.valid, 1'b0);
    @(posedge clk_sys);
    #1;
    check(reset_fetch, 1'b1);
    check(reset_vector, {5'h0, cause});
    check(fetch_addr, IVP_ADDR_W'(vector_table_base + {cause, 1'b0}));
    check(fetch_is_call, 1'b0);
    @(posedge clk_sys);
    #1;
    check(reset_fetch, 1'b0);
  endtask
  initial begin
    do_reset(1'b0);
    for (int i = 0; i < 400; i++) begin
      irq_req = NV'({$random(seed), $random(seed)} & {$random(seed), $random(seed)});
      irq_enable = NV'(~({$random(seed), $random(seed)} & {$random(seed), $random(seed)}));
      irq_level = (2 * NV)'({$random(seed), $random(seed), $random(seed), $random(seed)});
      // Out-of-range corners: all at level 3, then all at level 0
      if (i % 8 == 0) irq_level = '1;
      if (i % 8 == 1) irq_level = '0;
      if (i % 16 == 2) vector_table_base = 21'($random(seed));
      if (i == 100) vector_table_base = '1;
      exp_g = expect_grant();
      @(posedge clk_sys);
      #1;
      check(grant.valid, exp_g.valid);
      if (exp_g.valid) check(grant, exp_g);
      if (exp_g.valid) check(fetch_addr, exp_g.addr);
      check(fetch_is_call, 1'b1);
    end
    do_reset(1'b1);
    tally_and_finish();
  end
endmodule
